// *** core/psf_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - PWM start waits for the programmed split-capacitor charge period.
// - Charge wait only applies in single-ended split-capacitor mode.
// - Charge bits four and three both zero means no charge wait.
// - Codes 01000..01111 give 13 to 96.2 ms charge waits.
// - Codes 10000..10111 give 130 to 962 ms charge waits.
// - Codes 11000..11111 give 1300 to 9620 ms charge waits.
// - Trim register bit six reads one once trimming has completed.
// - Writing trim bit zero high launches trim with chosen method.
// - Fault input low forces all PWM and both group enables low.
// - After fault, wait the programmed period, then start a reset.
// - Fault code 0000 gives a wait below 1.3 ms.
// - Fault codes 1..10 give code times 1.3 ms.
// - Code 1011 and codes 11xx give the 13 ms maximum.
// - Surround channels form group one, the rest group two.
module psf_ctrl
    import psf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // Register access port
    input  wire logic       regWrite,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    // System controls
    input  wire logic       splitCapMode,
    input  wire logic       startReq,
    input  wire logic [5:0] surroundMask,
    input  wire logic       frameClk,
    // Modulator and power stage
    input  wire logic [5:0] pwmIn,
    input  wire logic       power_stage_fault_n,
    output logic      [5:0] pwmOut,
    output logic            shutdown_group1_enable,
    output logic            shutdown_group2_enable,
    output logic            faultResetReq,
    output logic            trimDone
);

    // ****************************************************************
    // Decoding functions
    // ****************************************************************
    // Charge code to ticks; the three decades share one mantissa table
    function automatic logic [16:0] chargeTicks(input logic [4:0] code);
        logic [16:0] base;
        base = CHARGE_BASE_TICKS[code[2:0]];
        case (code[4:3])
            2'h1: chargeTicks = base;
            2'h2: chargeTicks = 17'(base * CHARGE_X10);
            2'h3: chargeTicks = 17'(base * CHARGE_X100);
            default: chargeTicks = 17'h00000;
        endcase
    endfunction

    // Fault code to ticks of wait before the reset request
    function automatic logic [7:0] faultTicks(input logic [3:0] code);
        if (code == 4'h0) begin
            faultTicks = FAULT_MIN_TICKS;
        end else if (code > FAULT_MAX_CODE) begin
            faultTicks = FAULT_MAX_TICKS;
        end else begin
            faultTicks = 8'(FAULT_UNIT_TICKS * {4'h0, code});
        end
    endfunction

    // ****************************************************************
    // Registers and decode
    // ****************************************************************
    logic [4:0]  charge_q;
    logic [3:0]  fault_q;
    logic        trimMethod_q;
    logic        trimDone_q;
    logic        trimBusy_q;
    logic [7:0]  trimCnt_q;
    logic        framePrev_q;
    logic [15:0] preCnt_q;
    logic [16:0] timer_q;
    psf_state_t  state_q;
    psf_state_t  state_d;
    logic [16:0] timer_d;
    logic        timerLoad;
    logic [5:0]  pwm_q;
    logic        grp1_q;
    logic        grp2_q;
    logic        rstReq_q;
    logic [7:0]  rdata_q;

    wire wrCharge = regWrite && (regAddr == CHARGE_OFS);
    wire wrTrim   = regWrite && (regAddr == TRIM_OFS);
    wire wrFault  = regWrite && (regAddr == FAULT_OFS);
    // Writing 0x00 must also enable factory trim, so a factory
    // selection always launches; field trim needs the command bit
    wire trimLaunch = wrTrim && (regWdata[TRIM_CMD_BIT]
                      || !regWdata[TRIM_METHOD_BIT]);
    wire frameRise  = frameClk && !framePrev_q;
    wire trimStep   = trimMethod_q ? frameRise : 1'b1;
    wire trimTarget = trimMethod_q ? (trimCnt_q == TRIM_FIELD_FRAMES)
                                   : (trimCnt_q == TRIM_FACTORY_CYC);
    // Time base only runs from a trimmed oscillator
    wire tick = trimDone_q && (preCnt_q == 16'(TICK_CYCLES - 1));
    wire faulted = !power_stage_fault_n;
    wire timerZero = (timer_q == 17'h00000);
    wire [16:0] chargeLoad = splitCapMode ? chargeTicks(charge_q)
                                          : 17'h00000;

    // Read mux; undefined bits read zero
    wire [7:0] rdMux =
        (regAddr == CHARGE_OFS) ? {3'h0, charge_q} :
        (regAddr == TRIM_OFS)   ? {1'b0, trimDone_q, 4'h0,
                                   trimMethod_q, trimBusy_q} :
        (regAddr == FAULT_OFS)  ? {4'h0, fault_q} : 8'h00;

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        timerLoad = 1'b0;
        timer_d = (tick && !timerZero) ? timer_q - 17'h00001 : timer_q;
        case (state_q)
            ST_IDLE: begin
                if (startReq) begin
                    state_d = ST_CHARGE;
                    timerLoad = 1'b1;
                    timer_d = chargeLoad;
                end
            end
            ST_CHARGE: begin
                if (!startReq) begin
                    state_d = ST_IDLE;
                end else if (timerZero) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!startReq) begin
                    state_d = ST_IDLE;
                end
            end
            ST_FAULT: begin
                if (timerZero) begin
                    state_d = ST_RESET;
                end
            end
            ST_RESET: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A fault outside ST_FAULT overrides everything and restarts the wait
        if (faulted && state_q != ST_FAULT) begin
            state_d = ST_FAULT;
            timerLoad = 1'b1;
            timer_d = {9'h000, faultTicks(fault_q)};
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            charge_q     <= CHARGE_RST;
            fault_q      <= FAULT_RST;
            trimMethod_q <= TRIM_METHOD_RST;
        end else if (ce) begin
            if (wrCharge) charge_q <= regWdata[4:0];
            if (wrFault) fault_q <= regWdata[3:0];
            if (wrTrim) trimMethod_q <= regWdata[TRIM_METHOD_BIT];
        end
    end

    // ****************************************************************
    // Oscillator trim engine
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trimBusy_q  <= 1'b0;
            trimDone_q  <= 1'b0;
            trimCnt_q   <= 8'h00;
            framePrev_q <= 1'b0;
        end else if (ce) begin
            framePrev_q <= frameClk;
            if (trimLaunch) begin
                trimBusy_q <= 1'b1;
                trimDone_q <= 1'b0;
                trimCnt_q  <= 8'h00;
            end else if (trimBusy_q && trimTarget) begin
                trimBusy_q <= 1'b0;
                trimDone_q <= 1'b1;
            end else if (trimBusy_q && trimStep) begin
                trimCnt_q <= trimCnt_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Time base and sequencer
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preCnt_q <= 16'h0000;
            timer_q  <= 17'h00000;
            state_q  <= ST_IDLE;
        end else if (ce) begin
            // Restart the time base with each new wait, so that its
            // first tick is a whole one and the wait is not cut short
            preCnt_q <= (tick || timerLoad || !trimDone_q)
                        ? 16'h0000 : preCnt_q + 16'h0001;
            timer_q  <= timer_d;
            state_q  <= state_d;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Fault input gates outputs directly so the drop costs one clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_q    <= 6'h00;
            grp1_q   <= 1'b0;
            grp2_q   <= 1'b0;
            rstReq_q <= 1'b0;
            rdata_q  <= 8'h00;
        end else if (ce) begin
            pwm_q  <= (state_d == ST_RUN) ? pwmIn : 6'h00;
            // Group enables follow the surround membership
            grp1_q <= (state_d == ST_RUN) && |surroundMask;
            grp2_q <= (state_d == ST_RUN) && |(~surroundMask);
            rstReq_q <= (state_q == ST_RESET);
            rdata_q  <= rdMux;
        end
    end

    assign pwmOut                 = pwm_q;
    assign shutdown_group1_enable = grp1_q;
    assign shutdown_group2_enable = grp2_q;
    assign faultResetReq          = rstReq_q;
    assign trimDone               = trimDone_q;
    assign regRdata               = rdata_q;

endmodule // psf_ctrl

// *** common/psf_pkg.sv ***
package psf_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CHARGE_OFS = 8'h1A;
    localparam logic [7:0] TRIM_OFS   = 8'h1B;
    localparam logic [7:0] FAULT_OFS  = 8'h1C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         TRIM_CMD_BIT    = 0;
    localparam int         TRIM_METHOD_BIT = 1;
    localparam int         TRIM_DONE_BIT   = 6;
    localparam logic [4:0] CHARGE_RST      = 5'h00;
    localparam logic [3:0] FAULT_RST       = 4'h0;
    localparam logic       TRIM_METHOD_RST = 1'b0;

    // ****************************************************************
    // Timing: charge and fault waits count ticks of a 100 us time base
    // ****************************************************************
    localparam int TICK_US    = 100;
    localparam int CLK_MHZ    = 10;
    localparam int TICK_CYC   = TICK_US * CLK_MHZ;
    // Charge wait of the lowest decade, indexed by code bits 2..0
    // (13, 16.9, 23.4, 31.2, 41.6, 54.6, 72.8, 96.2 ms)
    localparam logic [7:0][16:0] CHARGE_BASE_TICKS = {
        17'h003C2, 17'h002D8, 17'h00222, 17'h001A0,
        17'h00138, 17'h000EA, 17'h000A9, 17'h00082
    };
    // The two upper code groups scale the same table by decades
    localparam logic [16:0] CHARGE_X10  = 17'h0000A;
    localparam logic [16:0] CHARGE_X100 = 17'h00064;
    // Fault wait unit is 1.3 ms, i.e. 13 ticks
    localparam logic [7:0]  FAULT_UNIT_TICKS = 8'h0D;
    localparam logic [7:0]  FAULT_MIN_TICKS  = 8'h01;
    localparam logic [7:0]  FAULT_MAX_TICKS  = 8'h82;
    localparam logic [3:0]  FAULT_MAX_CODE   = 4'hA;
    // Factory trim settles in a fixed number of clocks
    localparam logic [7:0]  TRIM_FACTORY_CYC = 8'h10;
    // Field trim observes this many frame clock periods
    localparam logic [7:0]  TRIM_FIELD_FRAMES = 8'h04;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_CHARGE = 5'h02,
        ST_RUN    = 5'h04,
        ST_FAULT  = 5'h08,
        ST_RESET  = 5'h10
    } psf_state_t;

endpackage

// *** bench/psf_ctrl_chk.sv ***
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module psf_ctrl_chk
    import psf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       ce,
    // Register port
    input wire logic       regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Datapath and stage
    input wire logic [5:0] surroundMask,
    input wire logic [5:0] pwmIn,
    input wire logic       power_stage_fault_n,
    input wire logic [5:0] pwmOut,
    input wire logic       shutdown_group1_enable,
    input wire logic       shutdown_group2_enable,
    input wire logic       faultResetReq,
    input wire logic       trimDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Stage outputs, grouped since a fault must drop all of them
    logic [7:0] outs;
    assign outs = {shutdown_group1_enable, shutdown_group2_enable, pwmOut};

    chk_fault_drops: assert property (
        ce && !power_stage_fault_n |=> outs == 8'h00)
        else $error("outputs still live after stage fault");
    chk_pwm_follow: assert property (
        $past(ce) && pwmOut != 6'h00 |-> pwmOut == $past(pwmIn))
        else $error("pwm output differs from delayed modulator bits");
    // Enables lag the mask by one edge, so compare with the mask seen
    chk_group1_members: assert property (
        shutdown_group1_enable |-> |$past(surroundMask))
        else $error("group one enabled without members");
    chk_group2_members: assert property (
        shutdown_group2_enable |-> !(&$past(surroundMask)))
        else $error("group two enabled without members");
    chk_pulse_single: assert property (
        faultResetReq |=> !faultResetReq)
        else $error("reset request longer than one cycle");
    chk_pulse_quiet: assert property (
        faultResetReq |-> outs == 8'h00)
        else $error("reset request while outputs live");
    chk_charge_rsvd: assert property (
        $past(regAddr) == CHARGE_OFS |-> regRdata[7:5] == 3'h0)
        else $error("charge register upper bits not zero");
    chk_fault_rsvd: assert property (
        $past(regAddr) == FAULT_OFS |-> regRdata[7:4] == 4'h0)
        else $error("fault register upper bits not zero");
    chk_factory_trim: assert property (
        ce && regWrite && regAddr == TRIM_OFS && regWdata[1:0] == 2'b00
        |=> !trimDone ##[14:17] trimDone)
        else $error("factory trim done flag out of time");

    // Main scenarios reached
    cov_fault: cover property (!power_stage_fault_n);
    cov_reset_req: cover property (faultResetReq);
    cov_trim: cover property ($rose(trimDone));
endmodule // psf_ctrl_chk

bind psf_ctrl psf_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk, .rstn,
    .ce, .regWrite, .regAddr, .regWdata, .regRdata, .surroundMask, .pwmIn,
    .power_stage_fault_n, .pwmOut, .shutdown_group1_enable,
    .shutdown_group2_enable, .faultResetReq, .trimDone);

// *** bench/psf_stage_model.sv ***
`timescale 1ns/1ps
// ****************
// Power stage model
// ****************
module psf_stage_model (
    // Clock
    clk,
    // Fault request from the bench
    faultCmd,
    // Fault line, active low
    power_stage_fault_n
);
    input  wire logic clk;
    input  wire logic faultCmd;
    output logic      power_stage_fault_n;

    // Fault changes only after an edge, so the design samples it cleanly
    initial power_stage_fault_n = 1'b1;
    always @(posedge clk) begin
        power_stage_fault_n <= !faultCmd;
    end
endmodule // psf_stage_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tb_top;
    import psf_pkg::*;
    localparam int TK = 4;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       regWrite = 1'b0;
    logic       splitCapMode = 1'b0;
    logic       startReq = 1'b0;
    logic       faultCmd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [3:0] frameDiv = 4'h0;
    logic [5:0] surroundMask = 6'h1C;
    logic [7:0] regRdata, rdv;
    logic [5:0] pwmOut;
    logic       shutdown_group1_enable, shutdown_group2_enable;
    logic       power_stage_fault_n, faultResetReq, trimDone;
    int         errorCnt = 0;
    int         samplesChecked = 0;
    int         n;
    // Address, write data, expected read back
    logic [23:0] rows [5] = '{24'h1AFF1F, 24'h1CFF0F, 24'h1D5500,
                              24'h1B0202, 24'h1AE808};

    always #50 clk = ~clk;
    // Frame clock is 16 cycles; counter also feeds modulator bits
    always @(posedge clk) frameDiv <= frameDiv + 4'h1;

    psf_ctrl #(.TICK_CYCLES(TK)) dut (.clk, .rstn, .ce(1'b1), .regWrite,
        .regAddr, .regWdata, .regRdata, .splitCapMode, .startReq,
        .surroundMask, .frameClk(frameDiv[3]),
        .pwmIn({2'b10, frameDiv}), .power_stage_fault_n, .pwmOut,
        .shutdown_group1_enable, .shutdown_group2_enable, .faultResetReq,
        .trimDone);
    psf_stage_model stage (.clk, .faultCmd, .power_stage_fault_n);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chkEq(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // Counts are bench values, so a range is fine here
    task automatic chkCnt(input int got, input int lo, input int hi);
        samplesChecked++;
        if (got < lo || got > hi) begin
            errorCnt++;
            $display("unexpected at %0t: %h vs %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        @(posedge clk);
        #1 rdv = regRdata;
    endtask
    // Cycles until a bench-visible flag rises, bounded
    task automatic waitFor(input int which, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((which ? trimDone : shutdown_group2_enable) !== 1'b1
                   && n < lim);
    endtask
    task automatic charge(input logic m, input logic [7:0] c, input int t);
        @(posedge clk);
        startReq <= 1'b0;
        splitCapMode <= m;
        wr(CHARGE_OFS, c);
        @(posedge clk);
        startReq <= 1'b1;
        waitFor(0, 60000);
        chkCnt(n, t ? t * TK : 2, t ? t * TK + TK + 4 : 2);
    endtask
    // Group enables pick up a new surround mask one edge after it lands
    task automatic grpChk(input logic [5:0] m, input logic [1:0] e);
        @(posedge clk);
        surroundMask <= m;
        @(posedge clk);
        #1 chkEq({6'h00, shutdown_group1_enable,
            shutdown_group2_enable}, {6'h00, e});
    endtask
    task automatic fault(input logic [3:0] c, input int t);
        wr(FAULT_OFS, {4'h0, c});
        @(posedge clk);
        faultCmd <= 1'b1;
        @(posedge clk);
        faultCmd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
            if (n == 1) chkEq({shutdown_group1_enable,
                shutdown_group2_enable, pwmOut}, 8'h00);
        end while (faultResetReq !== 1'b1 && n < 2000);
        chkCnt(n, t * TK, t * TK + TK + 8);
        waitFor(0, 100);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            rd(8'(CHARGE_OFS + a));
            chkEq(rdv, 8'h00);
        end
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chkEq(rdv, rows[i][7:0]);
        end
        wr(TRIM_OFS, 8'h00);
        waitFor(1, 100);
        chkCnt(n, 15, 18);
        rd(TRIM_OFS);
        chkEq(rdv, 8'h40);
        charge(1'b0, 8'h08, 0);
        charge(1'b1, 8'hE7, 0);
        charge(1'b1, 8'h08, 130);
        charge(1'b1, 8'h0F, 962);
        charge(1'b1, 8'h10, 1300);
        charge(1'b1, 8'h18, 13000);
        #1 chkEq({2'b00, pwmOut}, {4'h2, frameDiv - 4'h1});
        grpChk(6'h3F, 2'b10);
        grpChk(6'h00, 2'b01);
        grpChk(6'h1C, 2'b11);
        // Second reset mid-run, then the other trim method
        @(posedge clk);
        rstn <= 1'b0;
        startReq <= 1'b0;
        splitCapMode <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(TRIM_OFS);
        chkEq(rdv, 8'h00);
        wr(TRIM_OFS, 8'h03);
        waitFor(1, 120);
        chkCnt(n, 49, 67);
        rd(TRIM_OFS);
        chkEq(rdv, 8'h42);
        @(posedge clk);
        startReq <= 1'b1;
        waitFor(0, 100);
        fault(4'h0, 1);
        fault(4'h1, 13);
        fault(4'hA, 130);
        fault(4'hB, 130);
        fault(4'hE, 130);
        end_of_test();
    end

    // Watchdog well past the expected run of about 63k cycles
    initial begin
        #8000000;
        errorCnt++;
        end_of_test();
    end
endmodule // tb_top
